// *** logic/msi_source_id_mapper.sv ***
// msi_source_id_mapper: checks interrupt writes and maps source identifiers
// assumes: masters and translators share clk; config and strap are same-clock logic
//
// Notes on behaviour
// RL1 - each master and translator in one group
// RL2 - cross-group interrupt write is illegal
// RL3 - illegal write dropped or aborted, never valid; under POL_POISON it is forwarded valid with MSI_SRC_POISON
// RL4 - masters aim only at own-group translators
// RL5 - each group is its own identifier namespace
// RL6 - group translators share widths, accept all members
// RL7 - same identifier whichever translator is targeted
// RL8 - group assignment frozen after initialisation
// RL9 - client identifier is stream plus fixed offset
// RL10 - bridge identifier from requester by offset
// RL11 - direct master identifier fixed by design
// RL12 - incapable master cannot impersonate another
// RL13 - processing element writes get same protection
// RL14 - translation unit accesses coherent, flag one
// RL15 - stalled master never blocks other masters
// RL16 - root complex bridges terminate, never stall
// RL17 - identifiers dense per group from zero
// RL18 - illegal: ignored, aborted or non-aliasing identifier
// RL19 - stream passed unmodified, zero-extended plus offset
// RL20 - bridge stream is requester plus base above n
// RL21 - stream to identifier mapping one-to-one
// RL22 - fixed per-master table, group compare, flag
`timescale 1ns/100ps
`include "msi_map.svh"
module msi_source_id_mapper
  import msi_pkg::*;
(
  input  wire logic                     clk,                   // system clock
  input  wire logic                     rst_n,                 // sync reset, low
  input  wire illegal_policy_t          illegal_policy,        // strap, taken after reset
  input  wire logic                     cfg_valid,             // table write strobe
  input  wire logic                     cfg_trans,             // write translator table
  input  wire logic [`MSI_MIDX_W-1:0]   cfg_index,             // entry index
  input  wire master_entry_t            cfg_entry,             // master entry data
  input  wire logic [`MSI_GRP_W-1:0]    cfg_group,             // translator group
  input  wire logic                     cfg_lock,              // freeze tables
  output logic                          locked,                // tables frozen
  input  wire logic                     req_valid,             // write offered
  output logic                          req_ready,             // write taken
  input  wire logic [`MSI_MIDX_W-1:0]   req_master,            // sending master
  input  wire logic [`MSI_TIDX_W-1:0]   req_translator,        // target translator
  input  wire logic [`MSI_STREAM_W-1:0] req_stream_identifier, // stream or requester id
  input  wire logic [`MSI_EVT_W-1:0]    req_event_number,      // event number
  input  wire logic [`MSI_MASTERS-1:0]  fault_stall,           // per-master fault stall
  output logic                          out_valid,             // write to translator
  input  wire logic                     out_ready,             // translator takes it
  output logic [`MSI_TIDX_W-1:0]        out_translator,        // translator index
  output logic [`MSI_SRC_W-1:0]         out_source_identifier, // mapped identifier
  output logic [`MSI_EVT_W-1:0]         out_event_number,      // event number
  output logic                          resp_valid,            // completion pulse
  output logic                          resp_abort,            // write aborted
  output logic                          resp_ignored,          // write ignored
  output logic                          illegal_event,         // illegal write pulse
  output logic [`MSI_MASTERS-1:0]       terminate_on_fault,    // masters kept off stall
  output logic                          coherent_access_flag   // translation coherent
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic                     init;   // strap captured
    illegal_policy_t          policy; // illegal-write action
    logic                     ovalid; // output write pending
    logic [`MSI_TIDX_W-1:0]   otrans; // output translator
    logic [`MSI_SRC_W-1:0]    osrc;   // output identifier
    logic [`MSI_EVT_W-1:0]    oevt;   // output event
    logic                     rvalid; // response pulse
    logic                     rabort; // response is abort
    logic                     rign;   // response is ignored
    logic                     ill;    // illegal pulse
    logic [`MSI_MASTERS-1:0]  term;   // terminate vector
  } st_t;

  st_t  st_q;
  st_t  st_d;
  logic fire;      // request accepted this cycle
  logic stalled;   // sender is stalled on a fault
  map_if mi();     // lookup carrier

  // ------------------------------------------------------------
  // lookup table
  // ------------------------------------------------------------
  map_table u_table (
    .clk   (clk),
    .rst_n (rst_n),
    .mi    (mi)
  );

  // config and lookup requests go straight to the table
  always_comb begin
    mi.m_idx     = req_master;
    mi.t_idx     = req_translator;
    mi.stream    = req_stream_identifier; // used as given RL19
    mi.cfg_valid = cfg_valid;
    mi.cfg_trans = cfg_trans;
    mi.cfg_index = cfg_index;
    mi.cfg_entry = cfg_entry;
    mi.cfg_group = cfg_group;
    mi.cfg_lock  = cfg_lock;
  end

  // ------------------------------------------------------------
  // acceptance: a stall only holds its own master
  // ------------------------------------------------------------
  always_comb begin
    // bridges are never stalled, their faults terminate RL16
    stalled   = fault_stall[req_master] && !mi.term_vec[req_master]; // RL15
    // nothing passes until the tables are frozen
    req_ready = mi.locked && st_q.init && !stalled && (!st_q.ovalid || out_ready);
    fire      = req_valid && req_ready;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.rvalid = 1'h0;
    st_d.rabort = 1'h0;
    st_d.rign   = 1'h0;
    st_d.ill    = 1'h0;
    st_d.term   = mi.term_vec;
    // strap caught once, after reset release
    if (!st_q.init) begin
      st_d.init   = 1'h1;
      st_d.policy = illegal_policy;
    end
    // translator took the pending write
    if (st_q.ovalid && out_ready) begin
      st_d.ovalid = 1'h0;
    end
    if (fire) begin
      st_d.rvalid = 1'h1; // RL22
      st_d.otrans = req_translator;
      st_d.oevt   = req_event_number; // RL6
      if (mi.legal) begin
        st_d.ovalid = 1'h1;
        st_d.osrc   = mi.src_id; // RL7 RL9 RL10 RL11
      end else begin
        st_d.ill = 1'h1; // RL2 RL22
        case (st_q.policy)
          POL_ABORT: begin
            st_d.rabort = 1'h1; // RL3
          end
          POL_POISON: begin
            // reserved id aliases no legitimate master RL18
            st_d.ovalid = 1'h1;
            st_d.osrc   = `MSI_SRC_POISON; // RL12 RL13
          end
          default: begin
            st_d.rign = 1'h1; // write ignored RL3
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_comb begin
    locked                = mi.locked;
    out_valid             = st_q.ovalid;
    out_translator        = st_q.otrans;
    out_source_identifier = st_q.osrc;
    out_event_number      = st_q.oevt;
    resp_valid            = st_q.rvalid;
    resp_abort            = st_q.rabort;
    resp_ignored          = st_q.rign;
    illegal_event         = st_q.ill;
    terminate_on_fault    = st_q.term;
    coherent_access_flag  = `MSI_COHERENT_ACCESS_FLAG; // RL14
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FOREIGN_BLOCKED: assert property ( // RL2
    fire && mi.foreign |=> illegal_event && (!out_valid || out_source_identifier == `MSI_SRC_POISON))
    else $error("cross-group write produced a valid interrupt");

  AST_ABORT_OR_IGNORE: assert property ( // RL3
    fire && !mi.legal && st_q.policy != POL_POISON |=> !out_valid && (resp_abort ^ resp_ignored))
    else $error("illegal write neither dropped nor aborted");

  AST_POISON_ID: assert property ( // RL18
    fire && !mi.legal && st_q.policy == POL_POISON
      |=> out_valid && out_source_identifier == `MSI_SRC_POISON)
    else $error("illegal write carried an aliasing identifier");

  AST_INCAPABLE: assert property ( // RL12
    fire && mi.incapable |=> illegal_event && resp_valid)
    else $error("incapable master write not flagged");

  AST_PE_WRITE: assert property ( // RL13
    fire && mi.incapable |=> !(out_valid && out_source_identifier != `MSI_SRC_POISON))
    else $error("processing element write impersonated a master");

  AST_SAME_ID: assert property ( // RL7
    fire && mi.legal |=> out_valid && out_source_identifier == $past(mi.src_id)
      && out_translator == $past(req_translator))
    else $error("identifier differs from lookup");

  AST_LOCK_HOLDS: assert property ( // RL8
    locked |=> locked [*4])
    else $error("group tables unlocked during operation");

  AST_COHERENT: assert property ( // RL14
    coherent_access_flag == 1'h1)
    else $error("coherent access flag not one");

  AST_STALL_LOCAL: assert property ( // RL15
    req_valid && stalled |-> !req_ready ##1 (!req_ready || !$past(stalled)))
    else $error("stalled master accepted");

  AST_BRIDGE_NO_STALL: assert property ( // RL16
    locked && st_q.init && !out_valid && mi.term_vec[req_master] |-> req_ready)
    else $error("bridge master held by a stall");

  AST_ANSWER: assert property ( // RL22
    fire |=> resp_valid ##1 !resp_valid || $past(fire))
    else $error("accepted write without response");

  COV_LEGAL: cover property (fire && mi.legal ##1 out_valid);
  COV_FOREIGN: cover property (fire && mi.foreign ##1 illegal_event);
  COV_STALL: cover property (req_valid && stalled ##1 req_valid && !stalled);
  COV_BACKPRESS: cover property (out_valid && !out_ready ##1 out_valid && out_ready);

endmodule

// *** logic/msi_map.svh ***
// msi_map.svh: widths, encodings and fixed values of the source identifier mapper
// assumes: included by the package and the design files, by bare name
`ifndef MSI_MAP_SVH
`define MSI_MAP_SVH

// ------------------------------------------------------------
// sizes of the master and translator tables
// ------------------------------------------------------------
`define MSI_MASTERS   8
`define MSI_MIDX_W    3
`define MSI_TRANS     4
`define MSI_TIDX_W    2
`define MSI_GRP_W     2

// ------------------------------------------------------------
// identifier widths, common to every translator group
// ------------------------------------------------------------
`define MSI_RID_N     16
`define MSI_RCB_W     4
`define MSI_STREAM_W  20
`define MSI_SRC_W     20
`define MSI_EVT_W     16

// ------------------------------------------------------------
// fixed values
// ------------------------------------------------------------
`define MSI_SRC_POISON 20'hfffff
`define MSI_COHERENT_ACCESS_FLAG     1'h1

`endif

// *** logic/msi_pkg.sv ***
// msi_pkg: types shared by the mapper top, its table and the carrier
// assumes: msi_map.svh sits on the include path
package msi_pkg;
  `include "msi_map.svh"

  // ------------------------------------------------------------
  // kinds of master and illegal-write policies
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_DIRECT,
    KIND_CLIENT,
    KIND_BRIDGE,
    KIND_PE
  } master_kind_t;

  typedef enum logic [1:0] {
    POL_IGNORE,
    POL_ABORT,
    POL_POISON
  } illegal_policy_t;

  // one master table entry
  typedef struct packed {
    logic                     capable; // expected to send interrupt writes
    master_kind_t             kind;    // how the identifier is formed
    logic [`MSI_GRP_W-1:0]    grp;     // the one group of this master
    logic [`MSI_SRC_W-1:0]    offset;  // constant added to the identifier
    logic [`MSI_RCB_W-1:0]    rc_base; // bridge constant above bit n
  } master_entry_t;
endpackage

// *** logic/map_if.sv ***
// map_if: carrier between the mapper top and its lookup table
// assumes: one clock; the table answers lookups in the same cycle
`timescale 1ns/100ps
`include "msi_map.svh"
interface map_if;
  import msi_pkg::*;
  logic [`MSI_MIDX_W-1:0]   m_idx;    // master of the write
  logic [`MSI_TIDX_W-1:0]   t_idx;    // target translator
  logic [`MSI_STREAM_W-1:0] stream;   // incoming stream identifier
  logic                     legal;    // write may raise an interrupt
  logic                     foreign;  // target outside master's group
  logic                     incapable;// master not meant to send
  logic [`MSI_SRC_W-1:0]    src_id;   // mapped source identifier
  logic [`MSI_MASTERS-1:0]  term_vec; // masters that must not stall
  logic                     cfg_valid;// table write strobe
  logic                     cfg_trans;// write targets translator table
  logic [`MSI_MIDX_W-1:0]   cfg_index;// entry written
  master_entry_t            cfg_entry;// master entry data
  logic [`MSI_GRP_W-1:0]    cfg_group;// translator group data
  logic                     cfg_lock; // freeze the tables
  logic                     locked;   // tables frozen

  modport table_side (input m_idx, t_idx, stream, cfg_valid, cfg_trans, cfg_index,
                      cfg_entry, cfg_group, cfg_lock,
                      output legal, foreign, incapable, src_id, term_vec, locked);
  modport user_side (output m_idx, t_idx, stream, cfg_valid, cfg_trans, cfg_index,
                     cfg_entry, cfg_group, cfg_lock,
                     input legal, foreign, incapable, src_id, term_vec, locked);
endinterface

// *** logic/map_table.sv ***
// map_table: group tables and identifier arithmetic of the mapper
// assumes: config comes from same-clock logic before the lock
`timescale 1ns/100ps
`include "msi_map.svh"
module map_table
  import msi_pkg::*;
(
  input wire logic   clk,   // system clock
  input wire logic   rst_n, // synchronous reset, active low
  map_if.table_side  mi     // lookup and config carrier
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    master_entry_t [`MSI_MASTERS-1:0]               mst;  // per master
    logic [`MSI_TRANS-1:0][`MSI_GRP_W-1:0]          tgrp; // per translator
    logic                                           lock; // frozen
  } tbl_t;

  tbl_t st_q;
  tbl_t st_d;
  master_entry_t ent; // entry of the looking master
  logic [`MSI_SRC_W:0] sum; // identifier with carry bit

  // fixed, offset or bridge mapping; carry flags a wrap
  function automatic logic [`MSI_SRC_W:0] map_src(master_entry_t e,
                                                   logic [`MSI_STREAM_W-1:0] s);
    logic [`MSI_STREAM_W-1:0] sid;
    sid = s;
    case (e.kind)
      KIND_DIRECT: map_src = {1'h0, e.offset}; // fixed by design RL11
      KIND_CLIENT: map_src = {1'h0, s} + {1'h0, e.offset}; // RL9
      KIND_BRIDGE: begin
        sid = {e.rc_base, s[`MSI_RID_N-1:0]}; // RL20
        map_src = {1'h0, sid} + {1'h0, e.offset}; // RL10
      end
      default: map_src = {1'h1, `MSI_SRC_POISON};
    endcase
  endfunction

  // ------------------------------------------------------------
  // next state: writes only until the lock
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (mi.cfg_valid && !st_q.lock) begin
      if (mi.cfg_trans) begin
        st_d.tgrp[mi.cfg_index[`MSI_TIDX_W-1:0]] = mi.cfg_group; // RL1
      end else begin
        // offsets come from config, so ids can start at zero densely
        st_d.mst[mi.cfg_index] = mi.cfg_entry; // RL1 RL17
      end
    end
    if (mi.cfg_lock) begin
      st_d.lock = 1'h1; // never released but by reset RL8
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------
  // lookup: the id never depends on the translator index
  // ------------------------------------------------------------
  always_comb begin
    ent          = st_q.mst[mi.m_idx];
    sum          = map_src(ent, mi.stream); // RL7 RL19
    mi.src_id    = sum[`MSI_SRC_W-1:0];
    mi.incapable = !ent.capable || ent.kind == KIND_PE; // RL12 RL13
    mi.foreign   = ent.grp != st_q.tgrp[mi.t_idx]; // RL2 RL5
    // a wrapped sum or the reserved value would alias RL21
    mi.legal     = st_q.lock && !mi.incapable && !mi.foreign && !sum[`MSI_SRC_W]
                   && sum[`MSI_SRC_W-1:0] != `MSI_SRC_POISON; // RL6
    mi.locked    = st_q.lock;
    for (int i = 0; i < `MSI_MASTERS; i++) begin
      mi.term_vec[i] = st_q.mst[i].kind == KIND_BRIDGE; // RL16
    end
  end

endmodule

// *** bench/translator_model.sv ***
// translator_model: far side of the mapper, a group of interrupt translators
// assumes: same clock as the mapper; valid/ready handshake on the out_* port
`timescale 1ns/100ps
module translator_model (
  input  wire logic clk,       // system clock
  input  wire logic rst_n,     // sync reset, active low
  input  wire logic out_valid, // write offered by the mapper
  output logic      out_ready, // write taken this edge
  input  wire logic slow       // stall now and then
);
  // ------------------------------------------------------------
  // accept logic
  // ------------------------------------------------------------
  int taken; // writes received, handy in waves
  // every translator takes writes from any master of its group; stalls are random
  always @(posedge clk) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      taken     <= 0;
    end else begin
      out_ready <= !slow || ($urandom % 3 == 0);
      if (out_valid && out_ready) begin
        taken <= taken + 1;
      end
    end
  end
endmodule

// *** bench/tb_msi_source_id_mapper.sv ***
// tb_msi_source_id_mapper: random and corner interrupt writes against the mapper
// assumes: msi_map.svh on the include path; the mapper and translator model compiled first
`timescale 1ns/100ps
`include "msi_map.svh"
module tb_msi_source_id_mapper;
  import msi_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;  // clock, reset, far-side pace
  illegal_policy_t illegal_policy = POL_IGNORE, pol = POL_IGNORE; // strap and its copy
  logic cfg_valid = 1'b0, cfg_trans = 1'b0, cfg_lock = 1'b0; // config strobes
  logic [2:0] cfg_index = 3'h0;                   // entry written
  master_entry_t cfg_entry = '0;                  // master entry data
  logic [1:0] cfg_group = 2'h0;                   // translator group data
  logic req_valid = 1'b0;                         // write offered
  logic [2:0] req_master = 3'h0;                  // sender
  logic [1:0] req_translator = 2'h0;              // target
  logic [19:0] req_stream_identifier = 20'h0;     // stream id
  logic [15:0] req_event_number = 16'h0;          // event number
  logic [7:0] fault_stall = 8'h00;                // per-master stall
  logic locked, req_ready, out_valid, out_ready, resp_valid, resp_abort, resp_ignored;
  logic illegal_event, coherent_access_flag;      // pulse and constant flag
  logic [1:0] out_translator;                     // forwarded target
  logic [19:0] out_source_identifier;             // forwarded id
  logic [15:0] out_event_number;                  // forwarded event
  logic [7:0] terminate_on_fault;                 // bridges kept off stall
  int bad_count = 0, total_checks = 0;            // mismatches, comparisons
  master_entry_t tbl[8];                          // reference master table
  logic [1:0] tgrp[4] = '{2'h0, 2'h1, 2'h1, 2'h2}; // reference translator groups

  always #5 clk = ~clk; // 100 MHz

  msi_source_id_mapper dut (.clk(clk), .rst_n(rst_n), .illegal_policy(illegal_policy),
    .cfg_valid(cfg_valid), .cfg_trans(cfg_trans), .cfg_index(cfg_index), .cfg_entry(cfg_entry),
    .cfg_group(cfg_group), .cfg_lock(cfg_lock), .locked(locked), .req_valid(req_valid),
    .req_ready(req_ready), .req_master(req_master), .req_translator(req_translator),
    .req_stream_identifier(req_stream_identifier), .req_event_number(req_event_number),
    .fault_stall(fault_stall), .out_valid(out_valid), .out_ready(out_ready),
    .out_translator(out_translator), .out_source_identifier(out_source_identifier),
    .out_event_number(out_event_number), .resp_valid(resp_valid), .resp_abort(resp_abort),
    .resp_ignored(resp_ignored), .illegal_event(illegal_event),
    .terminate_on_fault(terminate_on_fault), .coherent_access_flag(coherent_access_flag));
  translator_model far (.clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_ready(out_ready), .slow(slow));

  // ------------------------------------------------------------
  // checking and reference helpers
  // ------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask

  // {legal, carry, id}; a wrapped sum or the reserved id is illegal
  function automatic logic [21:0] expect_out(input logic [2:0] m, input logic [1:0] t, input logic [19:0] s);
    logic [20:0] sum;
    master_entry_t e;
    e = tbl[m];
    case (e.kind)
      KIND_DIRECT: sum = {1'b0, e.offset};
      KIND_CLIENT: sum = {1'b0, s} + {1'b0, e.offset};
      default:     sum = {1'b0, e.rc_base, s[15:0]} + {1'b0, e.offset};
    endcase
    return {e.capable && e.kind != KIND_PE && e.grp == tgrp[t] && !sum[20] && sum[19:0] != 20'hfffff, sum};
  endfunction

  // one table write per edge, strobe left high for back-to-back writes
  task automatic cfg_w(input logic tr, input logic [2:0] i, input master_entry_t e, input logic [1:0] g);
    cfg_valid <= 1'b1;
    cfg_trans <= tr;
    cfg_index <= i;
    cfg_entry <= e;
    cfg_group <= g;
    @(posedge clk);
  endtask

  // offer one write, hold until taken or give up, then judge the answer one cycle on
  task automatic send(input logic [2:0] m, input logic [1:0] t, input logic [19:0] s, output logic took);
    logic [21:0] x;
    logic [15:0] e;
    int n;
    x = expect_out(m, t, s);
    e = 16'($urandom);
    req_valid <= 1'b1;
    req_master <= m;
    req_translator <= t;
    req_stream_identifier <= s;
    req_event_number <= e;
    n = 0;
    // look at ready between edges, where it has settled for the coming edge
    #1;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    took = (req_ready === 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    if (took) begin
      chk(resp_valid === 1'b1, "no completion");
      chk(illegal_event === !x[21], "illegal flag wrong");
      if (x[21] || pol == POL_POISON) begin
        chk(out_valid === 1'b1 && out_translator === t && out_event_number === e, "forward wrong");
        chk(out_source_identifier === (x[21] ? x[19:0] : 20'hfffff), "source id wrong");
      end else begin
        chk(out_valid === 1'b0 && resp_abort === (pol == POL_ABORT) && resp_ignored === (pol == POL_IGNORE),
            "illegal write leaked");
      end
    end
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // one full run under one illegal-write policy
  // ------------------------------------------------------------
  task automatic phase(input illegal_policy_t p);
    logic took;
    pol = p;
    illegal_policy <= p;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(locked === 1'b0 && req_ready === 1'b0 && out_valid === 1'b0 && resp_valid === 1'b0, "reset values");
    chk(coherent_access_flag === 1'b1, "coherent flag");
    @(posedge clk);
    for (int i = 0; i < 8; i++) cfg_w(1'b0, i[2:0], tbl[i], 2'h0);
    for (int i = 0; i < 4; i++) cfg_w(1'b1, i[2:0], '0, tgrp[i]);
    cfg_valid <= 1'b0;
    cfg_lock <= 1'b1;
    @(posedge clk);
    cfg_lock <= 1'b0;
    cfg_valid <= 1'b1;
    cfg_trans <= 1'b1;
    cfg_group <= 2'h3; // late write must be ignored
    #1 chk(locked === 1'b1, "not locked");
    @(posedge clk);
    cfg_valid <= 1'b0;
    send(3'h0, 2'h0, 20'h12345, took);
    send(3'h0, 2'h1, 20'h0, took);
    send(3'h2, 2'h1, 20'h0ffff, took);
    send(3'h2, 2'h2, 20'h0ffff, took);
    send(3'h3, 2'h1, 20'h0, took);
    send(3'h4, 2'h2, 20'h00001, took);
    send(3'h5, 2'h3, 20'h0000f, took);
    send(3'h5, 2'h3, 20'h00010, took);
    send(3'h7, 2'h3, 20'h0, took);
    send(3'h6, 2'h0, 20'h00000, took);
    chk(terminate_on_fault === 8'h04, "bridge mask");
    fault_stall <= 8'h06;
    send(3'h1, 2'h1, 20'h00002, took);
    chk(took === 1'b0, "stalled master taken");
    send(3'h2, 2'h1, 20'h00002, took);
    chk(took === 1'b1, "bridge stalled");
    send(3'h0, 2'h0, 20'h0, took);
    chk(took === 1'b1, "other master blocked");
    fault_stall <= 8'h00;
    for (int i = 0; i < 40; i++) begin
      slow <= 1'($urandom);
      send(3'($urandom), 2'($urandom), ($urandom % 2) ? 20'($urandom) : 20'($urandom % 16), took);
      chk(took === 1'b1, "request refused");
    end
    $display("test policy %0d done", p);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    void'($urandom(51));
    tbl[0] = '{1'b1, KIND_DIRECT, 2'h0, 20'h00005, 4'h0};
    tbl[1] = '{1'b1, KIND_CLIENT, 2'h1, 20'h00100, 4'h0};
    tbl[2] = '{1'b1, KIND_BRIDGE, 2'h1, 20'h00010, 4'h3};
    tbl[3] = '{1'b1, KIND_PE, 2'h1, 20'h00000, 4'h0};
    tbl[4] = '{1'b0, KIND_CLIENT, 2'h1, 20'h00000, 4'h0};
    tbl[5] = '{1'b1, KIND_CLIENT, 2'h2, 20'hffff0, 4'h0};
    tbl[6] = '{1'b1, KIND_CLIENT, 2'h0, 20'h00000, 4'h0};
    tbl[7] = '{1'b1, KIND_DIRECT, 2'h2, 20'h00000, 4'h0};
    @(posedge clk);
    phase(POL_IGNORE);
    phase(POL_ABORT);
    phase(POL_POISON);
    end_sim();
  end

  // a full run is under 2000 cycles; cut a hang well beyond that
  initial begin
    #100000;
    bad_count++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end
endmodule
